//--- ceiij_defs.svh
`ifndef CEIIJ_DEFS_SVH
`define CEIIJ_DEFS_SVH
// ----------------------------------------
// register indices on the plain port
// ----------------------------------------
`define CEIIJ_R_CMD    4'h0
`define CEIIJ_R_STAT   4'h1
`define CEIIJ_R_FLAGS  4'h2
`define CEIIJ_R_IPTR   4'h3
`define CEIIJ_R_CSEG   4'h4
`define CEIIJ_R_SPTR   4'h5
`define CEIIJ_R_SSEG   4'h6
`define CEIIJ_R_DIDX   4'h7
`define CEIIJ_R_ESEG   4'h8
`define CEIIJ_R_PNUM   4'h9
`define CEIIJ_R_CNT    4'hA
`define CEIIJ_R_OPND   4'hB
// ----------------------------------------
// command and flag field positions
// ----------------------------------------
`define CEIIJ_CMD_WORD 3
`define CEIIJ_CMD_REP  4
`define CEIIJ_FB_CARRY 0
`define CEIIJ_FB_PAR   2
`define CEIIJ_FB_AUX   4
`define CEIIJ_FB_ZERO  6
`define CEIIJ_FB_SIGN  7
`define CEIIJ_FB_STEP  8
`define CEIIJ_FB_IEN   9
`define CEIIJ_FB_DIR   10
`define CEIIJ_FB_OVF   11
`define CEIIJ_FLAGS_MASK 16'h0FD5
// ----------------------------------------
// reset values, lengths, vectors
// ----------------------------------------
`define CEIIJ_RST_WORD 16'h0000
`define CEIIJ_LEN_ONE  16'h0001
`define CEIIJ_LEN_TWO  16'h0002
`define CEIIJ_STK_STEP 16'h0002
`define CEIIJ_VEC_SEG  16'h0002
`define CEIIJ_BRK_TYPE 8'h03
`define CEIIJ_OVF_TYPE 8'h04
`endif

//--- ceiij_pkg.sv
package ceiij_pkg;
  // ----------------------------------------
  // command and state types
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_INC = 3'h0, OP_PORT_IN = 3'h1, OP_TRAP = 3'h2, OP_TRAP_BRK = 3'h3,
    OP_TRAP_OVF = 3'h4, OP_TRAP_RET = 3'h5, OP_BRANCH = 3'h6, OP_NONE = 3'h7
  } ceiij_op_e;

  typedef enum logic [2:0] {
    C_ABOVE = 3'h0, C_ABOVE_EQ = 3'h1, C_BELOW = 3'h2, C_BELOW_EQ = 3'h3,
    C_EQUAL = 3'h4, C_GREATER = 3'h5, C_GREATER_EQ = 3'h6, C_COUNT_ZERO = 3'h7
  } ceiij_cond_e;

  typedef enum logic [3:0] {
    ST_IDLE, ST_IO_RD, ST_MEM_WR, ST_PUSH_FL, ST_PUSH_SEG, ST_VEC_SEG,
    ST_PUSH_PTR, ST_VEC_PTR, ST_POP_PTR, ST_POP_SEG, ST_POP_FL
  } ceiij_st_e;

  typedef struct packed {
    ceiij_st_e   st;
    logic [15:0] flags, iptr, cseg, sptr, sseg, didx, eseg, pnum, cnt, opnd;
    logic [15:0] vec, rdata, bwdata;
    logic [19:0] baddr;
    logic        word, rep, taken, breq, bwe, bio, bword;
  } ceiij_state_s;
endpackage : ceiij_pkg

//--- ceiij_alu_if.sv
interface ceiij_alu_if;
  logic [15:0]        opnd;
  logic               word;
  logic [15:0]        flags;
  logic [15:0]        cnt;
  ceiij_pkg::ceiij_cond_e cond;
  logic [15:0]        sum;
  logic [15:0]        flags_inc;
  logic               taken;
  modport exec (output opnd, word, flags, cnt, cond, input sum, flags_inc, taken);
  modport alu  (input opnd, word, flags, cnt, cond, output sum, flags_inc, taken);
endinterface : ceiij_alu_if

//--- ceiij_alu.sv
`include "ceiij_defs.svh"
module ceiij_alu (
  ceiij_alu_if.alu a
);
  logic [15:0] s;
  logic        cy, zr, sg, ov;

  // ----------------------------------------
  // add-one with flag update
  // ----------------------------------------
  always_comb begin
    s = a.opnd + 16'h0001;
    if (!a.word) begin
      s[15:8] = a.opnd[15:8]; // byte form keeps the upper half
    end
    a.sum = s;
    a.flags_inc = a.flags; // carry stays as it was
    a.flags_inc[`CEIIJ_FB_AUX] = (a.opnd[3:0] == 4'hF);
    a.flags_inc[`CEIIJ_FB_PAR] = ~^s[7:0];
    a.flags_inc[`CEIIJ_FB_ZERO] = a.word ? (s == 16'h0000) : (s[7:0] == 8'h00);
    a.flags_inc[`CEIIJ_FB_SIGN] = a.word ? s[15] : s[7];
    a.flags_inc[`CEIIJ_FB_OVF] = a.word ? (a.opnd == 16'h7FFF)
                                        : (a.opnd[7:0] == 8'h7F);
  end

  // ----------------------------------------
  // branch condition test, flags only read
  // ----------------------------------------
  always_comb begin
    cy = a.flags[`CEIIJ_FB_CARRY];
    zr = a.flags[`CEIIJ_FB_ZERO];
    sg = a.flags[`CEIIJ_FB_SIGN];
    ov = a.flags[`CEIIJ_FB_OVF];
    case (a.cond)
      ceiij_pkg::C_ABOVE:      a.taken = !cy || !zr; // printed form kept
      ceiij_pkg::C_ABOVE_EQ:   a.taken = !cy;
      ceiij_pkg::C_BELOW:      a.taken = cy;
      ceiij_pkg::C_BELOW_EQ:   a.taken = cy || zr;
      ceiij_pkg::C_EQUAL:      a.taken = zr;
      ceiij_pkg::C_GREATER:    a.taken = (sg == ov) && !zr;
      ceiij_pkg::C_GREATER_EQ: a.taken = (sg == ov);
      ceiij_pkg::C_COUNT_ZERO: a.taken = (a.cnt == 16'h0000);
      default:                 a.taken = 1'b0;
    endcase
  end
endmodule : ceiij_alu

//--- ceiij_exec.sv
// Behaviour
// - add-one on byte or word sets aux, overflow, parity, sign, zero; carry kept.
// - port block input reads port at port number, writes extra segment:dest index.
// - dest index steps 1 or 2 per transfer, down when direction flag set.
// - port block input works singly or repeated, one transfer per repetition.
// - trap pushes flags word below stack, then clears single-step and enable.
// - trap then pushes code segment and loads it from type*4+2.
// - trap finally pushes instruction pointer and loads it from type*4.
// - a one-byte breakpoint form implies trap type 3.
// - overflow trap with overflow set is type 4, vectors 10H and 12H.
// - overflow trap with overflow clear does nothing but advance.
// - trap return pops pointer, segment, flags, stack up 2 after each.
// - taken branch adds sign-extended displacement; branches change no flags.
// - above branch taken when carry clear or zero clear, as printed.
// - above-or-equal branch taken when carry clear.
// - below and carry branches taken when carry set.
// - below-or-equal branch taken when carry set or zero set.
// - count-zero branch taken when count is 0, count left alone.
// - equal branch taken when zero flag set.
// - greater branch taken when sign equals overflow and zero clear.
// - greater-or-equal branch taken when sign equals overflow.
//
// The implementer's own choices: the address map and strobed register access.
`include "ceiij_defs.svh"
module ceiij_exec #(
  parameter int REG_AW = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [15:0] reg_rdata,
  output      logic        bus_req,
  output      logic        bus_we,
  output      logic        bus_io,
  output      logic        bus_word,
  output      logic [19:0] bus_addr,
  output      logic [15:0] bus_wdata,
  input  wire logic        bus_ack,
  input  wire logic [15:0] bus_rdata,
  output      logic        busy
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (REG_AW < 4) begin : g_bad_aw
    $error("reg_addr must be at least 4 bits wide");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // segment times 16 plus offset, wraps at 1 MiB
  function automatic logic [19:0] phys(input logic [15:0] seg,
                                       input logic [15:0] ofs);
    phys = {seg, 4'h0} + {4'h0, ofs};
  endfunction : phys

  // trap type times four gives the pointer slot
  function automatic logic [15:0] vec_of(input logic [7:0] ty);
    vec_of = {6'h00, ty, 2'b00};
  endfunction : vec_of

  // ----------------------------------------
  // state and the shared flag unit
  // ----------------------------------------
  localparam ceiij_pkg::ceiij_state_s RST_S = '{
    st: ceiij_pkg::ST_IDLE, flags: `CEIIJ_RST_WORD, iptr: `CEIIJ_RST_WORD,
    cseg: `CEIIJ_RST_WORD, sptr: `CEIIJ_RST_WORD, sseg: `CEIIJ_RST_WORD,
    didx: `CEIIJ_RST_WORD, eseg: `CEIIJ_RST_WORD, pnum: `CEIIJ_RST_WORD,
    cnt: `CEIIJ_RST_WORD, opnd: `CEIIJ_RST_WORD, vec: `CEIIJ_RST_WORD,
    rdata: `CEIIJ_RST_WORD, bwdata: `CEIIJ_RST_WORD, baddr: 20'h00000,
    word: 1'b0, rep: 1'b0, taken: 1'b0, breq: 1'b0, bwe: 1'b0, bio: 1'b0,
    bword: 1'b0
  };

  ceiij_pkg::ceiij_state_s q, n;
  ceiij_pkg::ceiij_op_e    op;
  ceiij_alu_if             au ();
  logic        idle;
  logic [15:0] delta;
  logic [15:0] nxt_cnt;
  logic [15:0] disp;
  logic [7:0]  ty;

  ceiij_alu u_alu (
    .a (au)
  );

  // the flag unit sees the stored operand and flags; command fields drive cond
  assign au.opnd  = q.opnd;
  assign au.word  = reg_wdata[`CEIIJ_CMD_WORD];
  assign au.flags = q.flags;
  assign au.cnt   = q.cnt;
  assign au.cond  = ceiij_pkg::ceiij_cond_e'(reg_wdata[7:5]);

  assign idle = (q.st == ceiij_pkg::ST_IDLE);
  assign op   = ceiij_pkg::ceiij_op_e'(reg_wdata[2:0]);
  assign disp = {{8{reg_wdata[15]}}, reg_wdata[15:8]};
  assign delta = q.word ? `CEIIJ_LEN_TWO : `CEIIJ_LEN_ONE;
  assign nxt_cnt = q.cnt - `CEIIJ_LEN_ONE;

  // ----------------------------------------
  // outputs, all from the state flops
  // ----------------------------------------
  assign reg_rdata = q.rdata;
  assign bus_req   = q.breq;
  assign bus_we    = q.bwe;
  assign bus_io    = q.bio;
  assign bus_word  = q.bword;
  assign bus_addr  = q.baddr;
  assign bus_wdata = q.bwdata;
  assign busy      = !idle;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = q;
    ty = reg_wdata[15:8];
    // read data stand one cycle only, zero otherwise
    n.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr[3:0])
        `CEIIJ_R_STAT:  n.rdata = {14'h0000, q.taken, !idle};
        `CEIIJ_R_FLAGS: n.rdata = q.flags;
        `CEIIJ_R_IPTR:  n.rdata = q.iptr;
        `CEIIJ_R_CSEG:  n.rdata = q.cseg;
        `CEIIJ_R_SPTR:  n.rdata = q.sptr;
        `CEIIJ_R_SSEG:  n.rdata = q.sseg;
        `CEIIJ_R_DIDX:  n.rdata = q.didx;
        `CEIIJ_R_ESEG:  n.rdata = q.eseg;
        `CEIIJ_R_PNUM:  n.rdata = q.pnum;
        `CEIIJ_R_CNT:   n.rdata = q.cnt;
        `CEIIJ_R_OPND:  n.rdata = q.opnd;
        default:        n.rdata = 16'h0000;
      endcase
    end

    // register writes and command start, only while idle
    // (a running sequence owns the architectural state)
    if (reg_wr && idle) begin
      case (reg_addr[3:0])
        `CEIIJ_R_FLAGS: n.flags = reg_wdata & `CEIIJ_FLAGS_MASK;
        `CEIIJ_R_IPTR:  n.iptr = reg_wdata;
        `CEIIJ_R_CSEG:  n.cseg = reg_wdata;
        `CEIIJ_R_SPTR:  n.sptr = reg_wdata;
        `CEIIJ_R_SSEG:  n.sseg = reg_wdata;
        `CEIIJ_R_DIDX:  n.didx = reg_wdata;
        `CEIIJ_R_ESEG:  n.eseg = reg_wdata;
        `CEIIJ_R_PNUM:  n.pnum = reg_wdata;
        `CEIIJ_R_CNT:   n.cnt = reg_wdata;
        `CEIIJ_R_OPND:  n.opnd = reg_wdata;
        `CEIIJ_R_CMD: begin
          n.word = reg_wdata[`CEIIJ_CMD_WORD];
          n.rep  = reg_wdata[`CEIIJ_CMD_REP];
          n.taken = 1'b0;
          case (op)
            ceiij_pkg::OP_INC: begin
              n.opnd  = au.sum;
              n.flags = au.flags_inc;
              n.iptr  = q.iptr + `CEIIJ_LEN_ONE;
            end
            ceiij_pkg::OP_BRANCH: begin
              n.taken = au.taken;
              // flags untouched on both paths
              if (au.taken) begin
                n.iptr = q.iptr + `CEIIJ_LEN_TWO + disp;
              end else begin
                n.iptr = q.iptr + `CEIIJ_LEN_TWO;
              end
            end
            ceiij_pkg::OP_PORT_IN: begin
              n.iptr = q.iptr + `CEIIJ_LEN_ONE;
              // repeated with zero count: no transfer at all
              if (!(reg_wdata[`CEIIJ_CMD_REP] && q.cnt == 16'h0000)) begin
                n.st = ceiij_pkg::ST_IO_RD;
                n.breq = 1'b1;
                n.bwe = 1'b0;
                n.bio = 1'b1;
                n.bword = reg_wdata[`CEIIJ_CMD_WORD];
                n.baddr = {4'h0, q.pnum};
              end
            end
            ceiij_pkg::OP_TRAP, ceiij_pkg::OP_TRAP_BRK, ceiij_pkg::OP_TRAP_OVF: begin
              if (op == ceiij_pkg::OP_TRAP) begin
                n.iptr = q.iptr + `CEIIJ_LEN_TWO;
              end else begin
                n.iptr = q.iptr + `CEIIJ_LEN_ONE; // one-byte forms
              end
              if (op == ceiij_pkg::OP_TRAP_BRK) begin
                ty = `CEIIJ_BRK_TYPE;
              end else if (op == ceiij_pkg::OP_TRAP_OVF) begin
                ty = `CEIIJ_OVF_TYPE; // slots 10H and 12H
              end
              n.vec = vec_of(ty);
              // overflow clear: only the pointer moves
              if (op != ceiij_pkg::OP_TRAP_OVF || q.flags[`CEIIJ_FB_OVF]) begin
                n.st = ceiij_pkg::ST_PUSH_FL;
                n.sptr = q.sptr - `CEIIJ_STK_STEP;
                n.breq = 1'b1;
                n.bwe = 1'b1;
                n.bio = 1'b0;
                n.bword = 1'b1;
                n.baddr = phys(q.sseg, q.sptr - `CEIIJ_STK_STEP);
                n.bwdata = q.flags;
              end
            end
            ceiij_pkg::OP_TRAP_RET: begin
              n.st = ceiij_pkg::ST_POP_PTR;
              n.breq = 1'b1;
              n.bwe = 1'b0;
              n.bio = 1'b0;
              n.bword = 1'b1;
              n.baddr = phys(q.sseg, q.sptr);
            end
            default: begin
              n.taken = 1'b0;
            end
          endcase
        end
        default: begin
          n.taken = q.taken;
        end
      endcase
    end

    // bus sequences advance on each acknowledge
    if (q.breq && bus_ack) begin
      n.breq = 1'b0;
      case (q.st)
        ceiij_pkg::ST_IO_RD: begin
          n.st = ceiij_pkg::ST_MEM_WR;
          n.breq = 1'b1;
          n.bwe = 1'b1;
          n.bio = 1'b0;
          n.baddr = phys(q.eseg, q.didx); // no override possible
          n.bwdata = bus_rdata;
        end
        ceiij_pkg::ST_MEM_WR: begin
          if (q.flags[`CEIIJ_FB_DIR]) begin
            n.didx = q.didx - delta;
          end else begin
            n.didx = q.didx + delta;
          end
          n.st = ceiij_pkg::ST_IDLE;
          if (q.rep) begin
            n.cnt = nxt_cnt;
            if (nxt_cnt != 16'h0000) begin
              n.st = ceiij_pkg::ST_IO_RD;
              n.breq = 1'b1;
              n.bwe = 1'b0;
              n.bio = 1'b1;
              n.baddr = {4'h0, q.pnum};
            end
          end
        end
        ceiij_pkg::ST_PUSH_FL: begin
          n.flags[`CEIIJ_FB_STEP] = 1'b0;
          n.flags[`CEIIJ_FB_IEN]  = 1'b0;
          n.st = ceiij_pkg::ST_PUSH_SEG;
          n.sptr = q.sptr - `CEIIJ_STK_STEP;
          n.breq = 1'b1;
          n.baddr = phys(q.sseg, q.sptr - `CEIIJ_STK_STEP);
          n.bwdata = q.cseg;
        end
        ceiij_pkg::ST_PUSH_SEG: begin
          n.st = ceiij_pkg::ST_VEC_SEG;
          n.breq = 1'b1;
          n.bwe = 1'b0;
          n.baddr = {4'h0, q.vec + `CEIIJ_VEC_SEG};
        end
        ceiij_pkg::ST_VEC_SEG: begin
          n.cseg = bus_rdata;
          n.st = ceiij_pkg::ST_PUSH_PTR;
          n.sptr = q.sptr - `CEIIJ_STK_STEP;
          n.breq = 1'b1;
          n.bwe = 1'b1;
          n.baddr = phys(q.sseg, q.sptr - `CEIIJ_STK_STEP);
          n.bwdata = q.iptr;
        end
        ceiij_pkg::ST_PUSH_PTR: begin
          n.st = ceiij_pkg::ST_VEC_PTR;
          n.breq = 1'b1;
          n.bwe = 1'b0;
          n.baddr = {4'h0, q.vec};
        end
        ceiij_pkg::ST_VEC_PTR: begin
          n.iptr = bus_rdata;
          n.st = ceiij_pkg::ST_IDLE;
        end
        ceiij_pkg::ST_POP_PTR: begin
          n.iptr = bus_rdata;
          n.sptr = q.sptr + `CEIIJ_STK_STEP;
          n.st = ceiij_pkg::ST_POP_SEG;
          n.breq = 1'b1;
          n.baddr = phys(q.sseg, q.sptr + `CEIIJ_STK_STEP);
        end
        ceiij_pkg::ST_POP_SEG: begin
          n.cseg = bus_rdata;
          n.sptr = q.sptr + `CEIIJ_STK_STEP;
          n.st = ceiij_pkg::ST_POP_FL;
          n.breq = 1'b1;
          n.baddr = phys(q.sseg, q.sptr + `CEIIJ_STK_STEP);
        end
        ceiij_pkg::ST_POP_FL: begin
          n.flags = bus_rdata & `CEIIJ_FLAGS_MASK; // every flag restored
          n.sptr = q.sptr + `CEIIJ_STK_STEP;
          n.st = ceiij_pkg::ST_IDLE;
        end
        default: begin
          n.st = ceiij_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RST_S;
    end else begin
      q <= n;
    end
  end
endmodule : ceiij_exec

//--- ceiij_exec_sva.sv
module ceiij_exec_sva #(
  parameter int REG_AW = 4
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata,
  input wire logic              bus_req,
  input wire logic              bus_we,
  input wire logic              bus_io,
  input wire logic              bus_word,
  input wire logic [19:0]       bus_addr,
  input wire logic [15:0]       bus_wdata,
  input wire logic              bus_ack,
  input wire logic [15:0]       bus_rdata,
  input wire logic              busy
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // command decode seen from the ports
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic       cmd_go;
  logic [2:0] cmd_op;
  // busy writes are dropped, so only idle commands count
  assign cmd_go = reg_wr && (reg_addr == '0) && !busy;
  assign cmd_op = reg_wdata[2:0];

  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_io);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_wr_mem;
    bus_req && bus_we |-> !bus_io;
  endproperty
  a_wr_mem: assert property (p_wr_mem) else $error("write went to port space");
  property p_port_rd;
    cmd_go && cmd_op == 3'h1 && !reg_wdata[4] |=> bus_req && bus_io && !bus_we;
  endproperty
  a_port_rd: assert property (p_port_rd) else $error("block input did not read port");
  property p_io_then_wr;
    bus_ack && bus_req && bus_io |=> ##[0:2] (bus_req && bus_we && !bus_io);
  endproperty
  a_io_then_wr: assert property (p_io_then_wr) else $error("no memory store after input");
  property p_trap_push;
    cmd_go && (cmd_op == 3'h2 || cmd_op == 3'h3) |=> bus_req && bus_we && !bus_io;
  endproperty
  a_trap_push: assert property (p_trap_push) else $error("trap did not push first");
  property p_ret_pop;
    cmd_go && cmd_op == 3'h5 |=> bus_req && !bus_we && !bus_io;
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop first");
  property p_busy;
    bus_req |-> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("request outside busy");
  property p_inc;
    cmd_go && cmd_op == 3'h0 |=> !busy && !bus_req;
  endproperty
  a_inc: assert property (p_inc) else $error("add-one used the bus");
  property p_branch;
    cmd_go && cmd_op == 3'h6 |=> (!busy && !bus_req) [*2];
  endproperty
  a_branch: assert property (p_branch) else $error("branch used the bus");
endmodule : ceiij_exec_sva

bind ceiij_exec ceiij_exec_sva #(.REG_AW(REG_AW)) ceiij_exec_sva_i (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
  .bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .busy(busy)
);

//--- ceiij_mem_model.sv
module ceiij_mem_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic        bus_io,
  input  wire logic        bus_word,
  input  wire logic [19:0] bus_addr,
  input  wire logic [15:0] bus_wdata,
  output      logic        bus_ack,
  output      logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // memory and ports behind the bus unit
  // ----------------------------------------
  logic [7:0]  mem [0:4095];
  logic [1:0]  wait_q;
  logic [11:0] a;
  // 4k image only: higher address bits alias
  assign a = bus_addr[11:0];
  // read data is scrambled outside the ack cycle so stale values never match
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_ack   <= 1'b0;
      bus_rdata <= 16'hA55A;
      wait_q    <= 2'h0;
    end else if (bus_ack) begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
    end else if (bus_req && (!slow || wait_q == 2'h3)) begin
      bus_ack <= 1'b1;
      wait_q  <= 2'h0;
      if (bus_io) begin
        bus_rdata <= {8'hC3, a[7:0]};
      end else if (bus_we) begin
        mem[a] <= bus_wdata[7:0];
        if (bus_word) begin
          mem[a + 12'h001] <= bus_wdata[15:8];
        end
      end else begin
        bus_rdata <= {mem[a + 12'h001], mem[a]};
      end
    end else begin
      wait_q    <= bus_req ? wait_q + 2'h1 : 2'h0;
      bus_rdata <= ~bus_rdata;
    end
  end
endmodule : ceiij_mem_model

//--- ceiij_exec_test.sv
module ceiij_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] fl;
    logic [15:0] cnt;
    logic [2:0]  cond;
    logic [7:0]  disp;
    logic        tk;
  } ceiij_row_s;
  logic        clock, rst, reg_wr, reg_rd, bus_req, bus_we, bus_io, bus_word, bus_ack, busy;
  logic        slow;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, bus_wdata, bus_rdata, exp_ptr;
  logic [19:0] bus_addr;
  int          failures, checks;
  ceiij_row_s  rows [16];

  ceiij_exec ceiij_exec_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_req(bus_req), .bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .busy(busy));
  ceiij_mem_model ceiij_mem_model_i (.clock(clock), .rst(rst), .slow(slow),
    .bus_req(bus_req), .bus_we(bus_we), .bus_io(bus_io), .bus_word(bus_word),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  // ----------------------------------------
  // register port and compare helpers
  // ----------------------------------------
  always #50 clock = ~clock;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rchk
  // bounded wait; a hang counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    @(posedge clock);
    #1;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 200) failures++;
  endtask : wait_idle
  task automatic pm(input logic [11:0] a, input logic [15:0] d);
    ceiij_mem_model_i.mem[a] = d[7:0];
    ceiij_mem_model_i.mem[a + 12'h001] = d[15:8];
  endtask : pm
  function automatic logic [15:0] mw(input logic [11:0] a);
    return {ceiij_mem_model_i.mem[a + 12'h001], ceiij_mem_model_i.mem[a]};
  endfunction : mw
  // trap then return; a write while busy must be dropped
  task automatic trap(input logic [15:0] cmd, input logic [7:0] t, input logic [15:0] adv);
    pm({2'b00, t, 2'b00}, {8'h40, t});
    pm({2'b00, t, 2'b00} + 12'h002, {8'h50, t});
    wr(4'h6, 16'h0000);
    wr(4'h5, 16'h0100);
    wr(4'h4, 16'h1234);
    wr(4'h3, 16'h0500);
    wr(4'h2, 16'h0B01);
    wr(4'h0, cmd);
    wr(4'h3, 16'hDEAD);
    // mid-sequence: status and the pin must both show the engine running
    rchk(4'h1, 16'h0001);
    chk({15'h0000, busy}, 16'h0001);
    wait_idle();
    rchk(4'h3, {8'h40, t});
    rchk(4'h4, {8'h50, t});
    rchk(4'h5, 16'h00FA);
    rchk(4'h2, 16'h0801);
    chk(mw(12'h0FE), 16'h0B01);
    chk(mw(12'h0FC), 16'h1234);
    chk(mw(12'h0FA), 16'h0500 + adv);
    wr(4'h0, 16'h0005);
    wait_idle();
    rchk(4'h3, 16'h0500 + adv);
    rchk(4'h4, 16'h1234);
    rchk(4'h2, 16'h0B01);
    rchk(4'h5, 16'h0100);
  endtask : trap
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #2000000;
    failures++;
    final_report();
  end
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    slow = 1'b0;
    rows = '{'{16'h0041, 16'h0001, 3'h0, 8'h10, 1'b0}, '{16'h0040, 16'h0001, 3'h0, 8'hF0, 1'b1},
      '{16'h0001, 16'h0001, 3'h1, 8'h10, 1'b0}, '{16'h0000, 16'h0001, 3'h1, 8'h7F, 1'b1},
      '{16'h0001, 16'h0001, 3'h2, 8'h80, 1'b1}, '{16'h0040, 16'h0001, 3'h2, 8'h10, 1'b0},
      '{16'h0040, 16'h0001, 3'h3, 8'hF0, 1'b1}, '{16'h0000, 16'h0001, 3'h3, 8'h10, 1'b0},
      '{16'h0040, 16'h0001, 3'h4, 8'h10, 1'b1}, '{16'h0001, 16'h0001, 3'h4, 8'h10, 1'b0},
      '{16'h0880, 16'h0001, 3'h5, 8'hF0, 1'b1}, '{16'h08C0, 16'h0001, 3'h5, 8'h10, 1'b0},
      '{16'h0080, 16'h0001, 3'h6, 8'h10, 1'b0}, '{16'h0880, 16'h0001, 3'h6, 8'hFE, 1'b1},
      '{16'h0000, 16'h0000, 3'h7, 8'h80, 1'b1}, '{16'h0000, 16'h0001, 3'h7, 8'h10, 1'b0}};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(4'h2, rows[i].fl);
      wr(4'hA, rows[i].cnt);
      wr(4'h3, 16'h1000);
      wr(4'h0, {rows[i].disp, rows[i].cond, 5'h06});
      exp_ptr = 16'h1002 + (rows[i].tk ? {{8{rows[i].disp[7]}}, rows[i].disp} : 16'h0000);
      rchk(4'h3, exp_ptr);
      rchk(4'h1, {14'h0000, rows[i].tk, 1'b0});
      rchk(4'h2, rows[i].fl);
      rchk(4'hA, rows[i].cnt);
    end
    // add-one, byte then word; carry must survive
    wr(4'hB, 16'h127F);
    wr(4'h2, 16'h0001);
    wr(4'h0, 16'h0000);
    rchk(4'hB, 16'h1280);
    rchk(4'h2, 16'h0891);
    wr(4'hB, 16'hFFFF);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0008);
    rchk(4'hB, 16'h0000);
    rchk(4'h2, 16'h0054);
    // repeated byte input with wait states, then a single word input going down
    slow <= 1'b1;
    ceiij_mem_model_i.mem[12'h213] = 8'hEE;
    wr(4'h9, 16'h0033);
    wr(4'h8, 16'h0020);
    wr(4'h7, 16'h0010);
    wr(4'hA, 16'h0003);
    wr(4'h0, 16'h0011);
    wait_idle();
    rchk(4'h7, 16'h0013);
    rchk(4'hA, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      chk({8'h00, ceiij_mem_model_i.mem[12'h210 + i]}, i < 3 ? 16'h0033 : 16'h00EE);
    end
    wr(4'h2, 16'h0400);
    wr(4'h7, 16'h0020);
    wr(4'h0, 16'h0009);
    wait_idle();
    rchk(4'h7, 16'h001E);
    chk(mw(12'h220), 16'hC333);
    wr(4'h0, 16'h0011);
    wait_idle();
    rchk(4'h7, 16'h001E);
    slow <= 1'b0;
    trap(16'h2102, 8'h21, 16'h0002);
    trap(16'h0003, 8'h03, 16'h0001);
    trap(16'h0004, 8'h04, 16'h0001);
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0500);
    wr(4'h0, 16'h0004);
    rchk(4'h1, 16'h0000);
    rchk(4'h3, 16'h0501);
    rchk(4'h5, 16'h0100);
    // spare operation code must leave pointer and stack alone
    wr(4'h0, 16'h0007);
    rchk(4'h3, 16'h0501);
    rchk(4'h5, 16'h0100);
    wr(4'hF, 16'h1234);
    rchk(4'hF, 16'h0000);
    // second reset while idle clears every register
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int i = 1; i < 12; i++) begin
      rchk(i[3:0], 16'h0000);
    end
    final_report();
  end
endmodule : ceiij_exec_test
